// ---- logic/rsc_sync.sv ----
// Purpose: Two-stage synchroniser for asynchronous levels
// Assumes: Inputs are slow levels, not pulses
// Notes:   The first stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module rsc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Levels
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      meta_ff <= '0;
      q_out <= '0;
    end else begin
      meta_ff <= d_in;
      q_out <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// ---- logic/rsc_timer.sv ----
// Purpose: Loadable down-counter for delays and the watchdog
// Assumes: Load values are at least one
// Notes:   Counting pauses while count_en is low; a load restarts it
`timescale 1ns/1ns
`default_nettype none
module rsc_timer import rsc_pkg::*; (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Control
  rsc_tmr_if.tmr tmr_if
);
  logic [TMR_W-1:0] cnt_ff;
  logic busy_ff;

  assign tmr_if.busy = busy_ff;
  assign tmr_if.done = busy_ff && tmr_if.count_en && !tmr_if.load && (cnt_ff == TMR_W'(1));

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
    end else if (tmr_if.load) begin
      cnt_ff <= tmr_if.load_val;
      busy_ff <= 1'b1;
    end else if (tmr_if.done) begin
      busy_ff <= 1'b0;
    end else if (busy_ff && tmr_if.count_en) begin
      cnt_ff <= cnt_ff - TMR_W'(1);
    end
  end
endmodule
`default_nettype wire

// ---- logic/rsc_top.sv ----
// Purpose: Reset-cause logging, start-up and suspend/wake sequencing
// Assumes: Supply comparators and D- line arrive asynchronously
// Notes:   CPU I/O writes and reads reach the registers directly
//
// What this block does
// - Reset cause is logged: status bit 4 supply low, bit 6 watchdog.
// - Every reset restarts fetching at 0x0000 with nothing pushed.
// - Reset clears all registers except the status/control register.
// - Reset floats pins, disables interrupts and USB.
// - Supply resets select the internal clock then wait the start-up time.
// - Watchdog reset keeps clock mode, skips settling, clears oscillator enable.
// - Reset loads both stack pointers with 0x00.
// - Above threshold a counter times start-up, then execution begins.
// - Enabled low-voltage reset repeats whenever the supply drops again.
// - Low-voltage reset is off in suspend and returns afterwards.
// - Brown-out guards while low-voltage reset is off; shared flag set.
// - Brown-out re-arms low-voltage reset and holds until supply recovers.
// - Any write to address 0x26 restarts the watchdog.
// - Watchdog expiry causes a watchdog reset and sets its flag.
// - Watchdog reset holds the part about 2 ms, then runs from 0x0000.
// - Suspend gates clocks and stops the watchdog timer.
// - Only pin, wake timer, SPI slave interrupts or D- low wake it.
// - Wake restarts clocks; run after oscillator stable and resume delay.
// - Any enabled pending interrupt wakes, whatever the sense bit says.
// - A wake present at suspend entry still enters suspend first.
// - Resume happens only while the run bit is set.
// - After waking one instruction runs before interrupts are serviced.
// - Clock config bit 3 set disables the low-voltage reset.
// - Oscillator enable bit picks internal or external clock for waking.
// - External wake delay is 4 ms with resume bit set, else 128 us.
// - Internal clock wake waits 8 us before execution.
`timescale 1ns/1ns
`default_nettype none
module rsc_top import rsc_pkg::*; #(
  parameter logic [TMR_W-1:0] STARTUP_CYC = STARTUP_CYC_DEF,
  parameter logic [TMR_W-1:0] WATCHDOG_CYC = WATCHDOG_CYC_DEF,
  parameter logic [TMR_W-1:0] WDR_HOLD_CYC = WDR_HOLD_CYC_DEF,
  parameter logic [TMR_W-1:0] EXT_LONG_CYC = EXT_LONG_CYC_DEF
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // CPU I/O access
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  output logic [7:0] io_rdata_out,
  // Supply monitors and oscillator, asynchronous
  input wire logic above_low_supply_threshold_in,
  input wire logic above_sag_trip_in,
  input wire logic ext_osc_stable_in,
  // Wake sources
  input wire logic pin_int_pending_in,
  input wire logic wake_timer_int_in,
  input wire logic spi_slave_int_in,
  input wire logic keyboard_data_line_in,
  // System control
  output logic sys_reset_out,
  output logic cpu_run_out,
  output logic stack_reset_out,
  output logic [12:0] fetch_vector_out,
  output logic [7:0] stack_ptr_init_out,
  output logic resume_defer_irq_out,
  output logic clk_gate_out,
  output logic int_osc_en_out,
  output logic ext_osc_en_out,
  output logic supply_low_reset_en_out
);
  // ------------------------------------------------------------
  // Input synchronisation
  // ------------------------------------------------------------
  logic [3:0] async_raw, async_s;
  logic lvr_ok_s, bor_ok_s, osc_ok_s, dminus_s;

  assign async_raw = {keyboard_data_line_in, ext_osc_stable_in, above_sag_trip_in,
                      above_low_supply_threshold_in};
  assign {dminus_s, osc_ok_s, bor_ok_s, lvr_ok_s} = async_s;
  rsc_sync #(.W(4)) u_sync (.clock_in(clock_in), .rst_b_in(rst_b_in), .d_in(async_raw),
    .q_out(async_s));

  // ------------------------------------------------------------
  // Timers
  // ------------------------------------------------------------
  rsc_tmr_if seq_if ();
  rsc_tmr_if wdt_if ();
  rsc_timer u_seq_tmr (.clock_in(clock_in), .rst_b_in(rst_b_in), .tmr_if(seq_if));
  rsc_timer u_wdt_tmr (.clock_in(clock_in), .rst_b_in(rst_b_in), .tmr_if(wdt_if));

  // ------------------------------------------------------------
  // Registers and decode
  // ------------------------------------------------------------
  rsc_state_t state_ff, nxt_state;
  logic [7:0] status_ff, cfg_ff;
  logic clk_mode_ext_ff, nxt_clk_ext, osc_low_seen_ff;
  logic status_wr, cfg_wr, wdt_clear_wr, suspend_req, lvr_on, supply_trip, wake_cond;
  logic lv_evt, wd_evt, rst_evt, susp_enter, nxt_in_reset;

  function automatic logic io_hit(input logic [7:0] addr);
    return io_wr_in && (io_addr_in == addr) && (state_ff == ST_RUN);
  endfunction

  assign status_wr = io_hit(ADDR_STATUS);
  assign cfg_wr = io_hit(ADDR_CLK_CFG);
  assign wdt_clear_wr = io_hit(ADDR_WDT_CLEAR);
  assign suspend_req = status_wr && io_wdata_in[STAT_SUSP_BIT];
  // Low-voltage guard only runs outside suspend and when not disabled
  assign lvr_on = !cfg_ff[CFG_LVR_DIS_BIT];
  assign supply_trip = lvr_on ? !lvr_ok_s : !bor_ok_s;
  // Pending interrupts arrive already masked by their enables
  assign wake_cond = pin_int_pending_in || wake_timer_int_in || spi_slave_int_in
                     || !dminus_s;
  assign lv_evt = (nxt_state == ST_POR_HOLD) && (state_ff != ST_POR_HOLD);
  assign wd_evt = (state_ff == ST_RUN) && (nxt_state == ST_WDR_HOLD);
  assign rst_evt = lv_evt || wd_evt;
  assign susp_enter = (state_ff == ST_RUN) && (nxt_state == ST_SUSPEND);
  assign nxt_in_reset = (nxt_state == ST_POR_HOLD) || (nxt_state == ST_STARTUP)
                        || (nxt_state == ST_WDR_HOLD);

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_POR_HOLD: begin
        if (lvr_ok_s) begin
          nxt_state = ST_STARTUP;
        end
      end
      ST_STARTUP: begin
        if (!lvr_ok_s) begin
          nxt_state = ST_POR_HOLD;
        end else if (seq_if.done) begin
          nxt_state = ST_RUN;
        end
      end
      ST_WDR_HOLD: begin
        if (supply_trip) begin
          nxt_state = ST_POR_HOLD;
        end else if (seq_if.done) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (supply_trip) begin
          nxt_state = ST_POR_HOLD;
        end else if (wdt_if.done) begin
          nxt_state = ST_WDR_HOLD;
        end else if (suspend_req) begin
          nxt_state = ST_SUSPEND;
        end
      end
      ST_SUSPEND: begin
        if (!bor_ok_s) begin
          nxt_state = ST_POR_HOLD;
        end else if (wake_cond && status_ff[STAT_RUN_BIT]) begin
          nxt_state = clk_mode_ext_ff ? ST_OSC_WAIT : ST_RESUME_DLY;
        end
      end
      ST_OSC_WAIT: begin
        if (!bor_ok_s) begin
          nxt_state = ST_POR_HOLD;
        end else if (osc_ok_s && osc_low_seen_ff) begin
          nxt_state = ST_RESUME_DLY;
        end
      end
      ST_RESUME_DLY: begin
        if (!bor_ok_s) begin
          nxt_state = ST_POR_HOLD;
        end else if (seq_if.done) begin
          nxt_state = ST_RUN;
        end
      end
      default: nxt_state = ST_POR_HOLD;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      state_ff <= ST_POR_HOLD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Delay timer is loaded on entry to each timed state
  always_comb begin
    seq_if.load = (nxt_state != state_ff) && ((nxt_state == ST_STARTUP)
                  || (nxt_state == ST_WDR_HOLD) || (nxt_state == ST_RESUME_DLY));
    seq_if.count_en = 1'b1;
    unique case (nxt_state)
      ST_STARTUP: seq_if.load_val = STARTUP_CYC;
      ST_WDR_HOLD: seq_if.load_val = WDR_HOLD_CYC;
      ST_RESUME_DLY: begin
        if (!clk_mode_ext_ff) begin
          seq_if.load_val = INT_WAKE_CYC;
        end else if (cfg_ff[CFG_RES_DLY_BIT]) begin
          seq_if.load_val = EXT_LONG_CYC;
        end else begin
          seq_if.load_val = EXT_SHORT_CYC;
        end
      end
      default: seq_if.load_val = STARTUP_CYC;
    endcase
  end

  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  // Stops in suspend and keeps its count until execution resumes
  assign wdt_if.count_en = (state_ff == ST_RUN);
  assign wdt_if.load = wdt_clear_wr
                       || ((nxt_state == ST_RUN) && nxt_in_reset == 1'b0
                           && (state_ff == ST_STARTUP || state_ff == ST_WDR_HOLD));
  assign wdt_if.load_val = WATCHDOG_CYC;

  // ------------------------------------------------------------
  // Status/control register
  // ------------------------------------------------------------
  // Not cleared by internal resets; later assignments win, so causes beat clears
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      status_ff <= STATUS_POR;
    end else begin
      if (status_wr) begin
        status_ff <= io_wdata_in;
      end
      if ((state_ff == ST_RESUME_DLY) && (nxt_state == ST_RUN)) begin
        status_ff[STAT_SUSP_BIT] <= 1'b0;
      end
      if (rst_evt) begin
        status_ff[STAT_SUSP_BIT] <= 1'b0;
        status_ff[STAT_RUN_BIT] <= 1'b1;
      end
      if (lv_evt) begin
        status_ff[STAT_LV_BIT] <= 1'b1;
      end
      if (wd_evt) begin
        status_ff[STAT_WD_BIT] <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Clock configuration and clock mode
  // ------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      cfg_ff <= CFG_RESET;
    end else if (rst_evt) begin
      cfg_ff <= CFG_RESET;
    end else if (cfg_wr) begin
      cfg_ff <= io_wdata_in;
    end
  end

  // The enable bit only changes the running mode at suspend entry
  always_comb begin
    nxt_clk_ext = clk_mode_ext_ff;
    if (lv_evt) begin
      nxt_clk_ext = 1'b0;
    end else if (susp_enter) begin
      nxt_clk_ext = cfg_ff[CFG_EXT_OSC_BIT];
    end
  end

  // Stable must read low after suspend entry: the synchroniser lags the oscillator
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      clk_mode_ext_ff <= 1'b0;
      osc_low_seen_ff <= 1'b0;
    end else begin
      clk_mode_ext_ff <= nxt_clk_ext;
      osc_low_seen_ff <= !susp_enter && (osc_low_seen_ff || !osc_ok_s);
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      sys_reset_out <= 1'b1;
      cpu_run_out <= 1'b0;
      stack_reset_out <= 1'b0;
      resume_defer_irq_out <= 1'b0;
      fetch_vector_out <= RESET_VECTOR;
      stack_ptr_init_out <= STACK_RESET;
    end else begin
      sys_reset_out <= nxt_in_reset;
      cpu_run_out <= (nxt_state == ST_RUN);
      // CPU loads the vector and stack pointers without any push
      stack_reset_out <= (nxt_state == ST_RUN) && !cpu_run_out
                         && (state_ff != ST_RESUME_DLY);
      resume_defer_irq_out <= (nxt_state == ST_RUN)
                              && (state_ff == ST_RESUME_DLY);
      fetch_vector_out <= RESET_VECTOR;
      stack_ptr_init_out <= STACK_RESET;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      clk_gate_out <= 1'b0;
      int_osc_en_out <= 1'b1;
      ext_osc_en_out <= 1'b0;
      supply_low_reset_en_out <= 1'b1;
    end else begin
      clk_gate_out <= (nxt_state == ST_SUSPEND);
      int_osc_en_out <= (nxt_state != ST_SUSPEND) && !nxt_clk_ext;
      ext_osc_en_out <= (nxt_state != ST_SUSPEND) && nxt_clk_ext;
      supply_low_reset_en_out <= (nxt_in_reset || (nxt_state == ST_RUN))
                                 && (rst_evt || !cfg_ff[CFG_LVR_DIS_BIT]);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      io_rdata_out <= 8'h00;
    end else if (io_rd_in && (io_addr_in == ADDR_STATUS)) begin
      io_rdata_out <= status_ff;
    end else if (io_rd_in && (io_addr_in == ADDR_CLK_CFG)) begin
      io_rdata_out <= cfg_ff;
    end else begin
      io_rdata_out <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_b_in);
  chk_lv_flag_set: assert property (lv_evt |=> status_ff[STAT_LV_BIT])
    else $error("supply reset did not record its cause");
  chk_wd_reset_entry: assert property (
    (state_ff == ST_RUN) && wdt_if.done && !supply_trip
    |=> status_ff[STAT_WD_BIT] && (state_ff == ST_WDR_HOLD) && sys_reset_out)
    else $error("watchdog expiry did not cause a watchdog reset");
  chk_run_at_vector: assert property (
    $rose(cpu_run_out) && $past(sys_reset_out)
    |-> stack_reset_out && (fetch_vector_out == RESET_VECTOR))
    else $error("release from reset without vector load");
  chk_reset_quiet: assert property (sys_reset_out |-> !cpu_run_out)
    else $error("cpu running while reset is asserted");
  chk_lv_int_clock: assert property (
    lv_evt |=> int_osc_en_out && !ext_osc_en_out && !clk_mode_ext_ff)
    else $error("supply reset did not select internal clock");
  chk_wd_keeps_mode: assert property (
    wd_evt |=> (clk_mode_ext_ff == $past(clk_mode_ext_ff)) && !cfg_ff[CFG_EXT_OSC_BIT])
    else $error("watchdog reset changed the clock mode");
  chk_wake_needs_run: assert property (
    (state_ff == ST_SUSPEND) && !status_ff[STAT_RUN_BIT] && bor_ok_s
    |=> (state_ff == ST_SUSPEND))
    else $error("left suspend with run bit clear");
  chk_int_wake_delay: assert property (
    (state_ff == ST_SUSPEND) && (nxt_state == ST_RESUME_DLY) && !clk_mode_ext_ff && bor_ok_s
    |=> !cpu_run_out ##79 (state_ff != ST_RUN) ##1 (state_ff == ST_RUN)
        || (state_ff == ST_POR_HOLD))
    else $error("internal clock wake delay is not 8 us");
  chk_suspend_stops: assert property (
    (state_ff == ST_SUSPEND) |-> clk_gate_out && !wdt_if.count_en && !cpu_run_out)
    else $error("clocks or watchdog still running in suspend");
  chk_wdr_hold_time: assert property (
    wd_evt |=> (sys_reset_out && (state_ff == ST_WDR_HOLD))[*8])
    else $error("watchdog reset hold ended too soon");
endmodule
`default_nettype wire

// ---- shared/rsc_pkg.sv ----
// Purpose: Shared constants for the reset and suspend sequencer
// Assumes: 10 MHz sequencer clock
// Notes:   Times are kept in microseconds and turned into cycle counts here
package rsc_pkg;
  // ------------------------------------------------------------
  // I/O map and field positions
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_WDT_CLEAR = 8'h26;
  localparam logic [7:0] ADDR_CLK_CFG = 8'hf8;
  localparam logic [7:0] ADDR_STATUS = 8'hff;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_IES_BIT = 2;
  localparam int STAT_SUSP_BIT = 3;
  localparam int STAT_LV_BIT = 4;
  localparam int STAT_WD_BIT = 6;
  localparam int CFG_EXT_OSC_BIT = 0;
  localparam int CFG_LVR_DIS_BIT = 3;
  localparam int CFG_RES_DLY_BIT = 7;
  // Power-on: run bit set and supply-low cause recorded
  localparam logic [7:0] STATUS_POR = 8'h11;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [7:0] STACK_RESET = 8'h00;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int TMR_W = 20;
  localparam int CLK_KHZ = 10000;
  localparam int INT_WAKE_DLY_US = 8;
  localparam int EXT_SHORT_DLY_US = 128;
  localparam int EXT_LONG_DLY_US = 4000;
  localparam int WDR_HOLD_US = 2000;
  localparam logic [TMR_W-1:0] INT_WAKE_CYC = TMR_W'(INT_WAKE_DLY_US * CLK_KHZ / 1000);
  localparam logic [TMR_W-1:0] EXT_SHORT_CYC = TMR_W'(EXT_SHORT_DLY_US * CLK_KHZ / 1000);
  localparam logic [TMR_W-1:0] EXT_LONG_CYC_DEF = TMR_W'(EXT_LONG_DLY_US * CLK_KHZ / 1000);
  localparam logic [TMR_W-1:0] WDR_HOLD_CYC_DEF = TMR_W'(WDR_HOLD_US * CLK_KHZ / 1000);
  // Start-up time-out and watchdog period have no printed figure
  localparam logic [TMR_W-1:0] STARTUP_CYC_DEF = 20'h04e20;
  localparam logic [TMR_W-1:0] WATCHDOG_CYC_DEF = 20'h186a0;
  // ------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_POR_HOLD = 7'h01,
    ST_STARTUP = 7'h02,
    ST_WDR_HOLD = 7'h04,
    ST_RUN = 7'h08,
    ST_SUSPEND = 7'h10,
    ST_OSC_WAIT = 7'h20,
    ST_RESUME_DLY = 7'h40
  } rsc_state_t;
endpackage

// ---- shared/rsc_tmr_if.sv ----
// Purpose: Link between the sequencer and one down-counting timer
// Assumes: rsc_pkg compiled first
// Notes:   done is a one-cycle pulse on the last counted cycle
`timescale 1ns/1ns
`default_nettype none
interface rsc_tmr_if import rsc_pkg::*; ();
  logic load;
  logic [TMR_W-1:0] load_val;
  logic count_en;
  logic done;
  logic busy;
  modport ctrl (output load, output load_val, output count_en, input done, input busy);
  modport tmr (input load, input load_val, input count_en, output done, output busy);
endinterface
`default_nettype wire

// ---- tb/rsc_far_model.sv ----
// Purpose: Far-side model: supply comparators, resonator and D- line
// Assumes: Runs from the bench clock
// Notes:   Resonator reports stable a fixed time after it is enabled
`timescale 1ns/1ns
`default_nettype none
module rsc_far_model #(
  parameter int OSC_START = 12
) (
  // Clock
  input wire logic clock_in,
  // Bench controls
  input wire logic vcc_hi_in,
  input wire logic vcc_sag_ok_in,
  input wire logic dm_active_in,
  input wire logic ext_osc_en_in,
  // Towards the block
  output logic lvr_ok_out,
  output logic sag_ok_out,
  output logic osc_stable_out,
  output logic dm_line_out
);
  int cnt = 0;
  // Stability drops at once when the resonator is switched off
  always @(posedge clock_in) begin
    cnt <= ext_osc_en_in ? cnt + 1 : 0;
  end
  assign osc_stable_out = ext_osc_en_in && cnt >= OSC_START;
  // The sag trip point lies below the low threshold, so a sag is also low
  assign lvr_ok_out = vcc_hi_in && vcc_sag_ok_in;
  assign sag_ok_out = vcc_sag_ok_in;
  // Idle bus holds D- high; activity pulls it low
  assign dm_line_out = !dm_active_in;
endmodule
`default_nettype wire

// ---- tb/tb_reset_and_suspend_control.sv ----
// Purpose: Self-checking bench for the reset and suspend sequencer
// Assumes: Long counts shortened through the top parameters
// Notes:   Expected status byte is kept in the bench
`timescale 1ns/1ns
`default_nettype none
module tb_reset_and_suspend_control import rsc_pkg::*; ;
  logic clk = 0, rstb = 0, wr = 0, rd = 0, vhi = 1, vsag = 1, dact = 0;
  logic pin = 0, wkt = 0, spi = 0;
  logic [7:0] addr = 0, wd = 0, rdat, sp;
  logic sysr, run, srst, dfr, gate, io, eo, lvre, lok, sok, ost, dm;
  logic [12:0] vec;
  int n_mismatch = 0, tests_run = 0, est, c, d;
  always #50 clk = ~clk;
  rsc_top #(.STARTUP_CYC(20'h14), .WATCHDOG_CYC(20'hc8), .WDR_HOLD_CYC(20'h14),
    .EXT_LONG_CYC(20'h28)) dut (.clock_in(clk), .rst_b_in(rstb), .io_wr_in(wr),
    .io_rd_in(rd), .io_addr_in(addr), .io_wdata_in(wd), .io_rdata_out(rdat),
    .above_low_supply_threshold_in(lok), .above_sag_trip_in(sok),
    .ext_osc_stable_in(ost), .pin_int_pending_in(pin), .wake_timer_int_in(wkt),
    .spi_slave_int_in(spi), .keyboard_data_line_in(dm), .sys_reset_out(sysr),
    .cpu_run_out(run), .stack_reset_out(srst), .fetch_vector_out(vec),
    .stack_ptr_init_out(sp), .resume_defer_irq_out(dfr), .clk_gate_out(gate),
    .int_osc_en_out(io), .ext_osc_en_out(eo), .supply_low_reset_en_out(lvre));
  rsc_far_model far (.clock_in(clk), .vcc_hi_in(vhi), .vcc_sag_ok_in(vsag),
    .dm_active_in(dact), .ext_osc_en_in(eo), .lvr_ok_out(lok), .sag_ok_out(sok),
    .osc_stable_out(ost), .dm_line_out(dm));
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic wr8(logic [7:0] a, logic [7:0] v);
    @(negedge clk);
    wr = 1;
    addr = a;
    wd = v;
    @(negedge clk);
    wr = 0;
  endtask
  task automatic rd8(logic [7:0] a, logic [7:0] e, string nm);
    @(negedge clk);
    rd = 1;
    addr = a;
    @(negedge clk);
    rd = 0;
    chk(nm, e, rdat);
  endtask
  // Bounded wait for the run flag to reach a level; n counts cycles
  task automatic wait_run(logic v, int lim, output int n);
    n = 0;
    while (run !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #(10000 * 100);
    n_mismatch++;
    close_out();
  end
  initial begin
    void'($urandom(6666));
    repeat (4) @(negedge clk);
    chk("sysr", 1, sysr);
    chk("intosc", 1, io);
    chk("lvren", 1, lvre);
    rstb = 1;
    wait_run(1, 80, c);
    chk("startup", 1, c >= 20 && c <= 30);
    chk("stkrst", 1, srst);
    chk("vector", 0, vec);
    chk("stackptr", 0, sp);
    est = 'h11;
    rd8(ADDR_STATUS, est, "status");
    rd8(ADDR_CLK_CFG, 0, "cfg");
    rd8(ADDR_WDT_CLEAR, 0, "wdclr");
    rd8(8'h40, 0, "unmapped");
    // Clears with random data keep it alive well past one period
    for (int i = 0; i < 4; i++) begin
      repeat (100 + $urandom % 80) @(negedge clk);
      wr8(ADDR_WDT_CLEAR, 8'($urandom));
      chk("wdalive", 1, run);
    end
    wr8(ADDR_CLK_CFG, 8'h01);
    wait_run(0, 260, c);
    chk("wdexpire", 1, c >= 190 && c <= 215);
    wait_run(1, 60, c);
    chk("wdhold", 1, c >= 18 && c <= 26);
    chk("wdclk", 1, io && !eo);
    est = 'h51;
    rd8(ADDR_STATUS, est, "wdcause");
    rd8(ADDR_CLK_CFG, 0, "wdcfg");
    // Each wake source in turn; the first is already present at entry
    for (int i = 0; i < 4; i++) begin
      pin = i == 0;
      wr8(ADDR_STATUS, 8'h09);
      chk("gate", 1, gate && !run && !lvre);
      repeat (5) @(negedge clk);
      wkt = i == 1;
      spi = i == 2;
      dact = i == 3;
      wait_run(1, 120, c);
      chk("intwake", 1, c >= 70 && c <= 92);
      chk("defer", 1, dfr);
      {pin, wkt, spi, dact} = 0;
      rd8(ADDR_STATUS, 8'h01, "resumed");
      chk("lvrback", 1, lvre);
    end
    // External clock resume, long then short delay
    for (int i = 0; i < 2; i++) begin
      d = i ? 1280 : 40;
      wr8(ADDR_CLK_CFG, i ? 8'h01 : 8'h81);
      wr8(ADDR_STATUS, 8'h09);
      pin = 1;
      wait_run(1, 1400, c);
      chk("extwake", 1, c >= d + 12 && c <= d + 25);
      chk("extclk", 1, eo && !io);
      pin = 0;
    end
    wr8(ADDR_STATUS, 8'h08);
    pin = 1;
    repeat (150) @(negedge clk);
    chk("norun", 0, run);
    pin = 0;
    vsag = 0;
    repeat (6) @(negedge clk);
    chk("sagrst", 1, sysr && io && !eo);
    vsag = 1;
    wait_run(1, 80, c);
    chk("sagstart", 1, c >= 20 && c <= 30);
    rd8(ADDR_STATUS, 8'h11, "sagcause");
    wr8(ADDR_CLK_CFG, 8'h08);
    // The enable output follows the stored disable bit one cycle later
    @(negedge clk);
    chk("lvroff", 0, lvre);
    vhi = 0;
    repeat (30) @(negedge clk);
    chk("lvrign", 1, run);
    vhi = 1;
    wr8(ADDR_CLK_CFG, 8'h00);
    vhi = 0;
    repeat (6) @(negedge clk);
    chk("lvrtrip", 1, sysr);
    vhi = 1;
    wait_run(1, 80, c);
    chk("lvrstart", 1, c >= 20 && c <= 30);
    close_out();
  end
endmodule
`default_nettype wire
